// >>> dma_parameter_memory_index_link_update.sv
// DMA parameter-set update engine: parameter memory, event service,
// transfer requests, array and frame index updates,
// reload updates and null or dummy set handling.
// Assumes one 10 MHz clock, a transfer controller that always accepts a request,
// and software on a plain word-addressed register port.
//
// How it works
// R01 - Source array index is a signed 16-bit byte step between source arrays.
// R02 - Destination array index is a signed 16-bit step between destination arrays.
// R03 - Source frame index steps from the current source array to next frame.
// R04 - Destination frame index steps likewise, same current-array choice as source.
// R05 - An exhausted set is reloaded from the set the reload pointer addresses.
// R06 - Software keeps the reload pointer 32-byte aligned.
// R07 - The top two reload pointer bits are ignored.
// R08 - Software keeps reload pointers inside implemented parameter memory.
// R09 - Pointer all-ones writes a zero set whose pointer stays all-ones.
// R10 - Null set: event-missed flag set, secondary-event flag stays set.
// R11 - While secondary flag stays set, events are ignored until software clears it.
// R12 - Dummy set: legal zero-byte transfer, secondary flag cleared, missed flag clear.
// R13 - Null and dummy sets still reload when not static, quick flag still set.
// R14 - Null and dummy sets raise pending-interrupt or chained flag as configured.
// R15 - A reload copies all eight words into the current channel's set.
// R16 - A static set gets neither reload nor address and count updates.
// R17 - Counts are 16-bit unsigned bytes, arrays per frame, frames per block.
// R18 - Indexes are sign-extended and added modulo 2^32, no overflow check.
`timescale 1ns/1ps
`include "dma_link_defs.svh"

module dma_parameter_memory_index_link_update
    import dma_link_pkg::*;
#(
    parameter int NUM_CH   = 8,
    parameter int NUM_SETS = 16
)
(
    input  wire logic                ref_clk_i,
    input  wire logic                arst_n_i,
    input  wire logic [`ADDR_W-1:0] addr_i,
    input  wire logic [31:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [31:0]         rdata_o,
    input  wire logic [NUM_CH-1:0]   event_i,
    output logic                     tr_valid_o,
    output logic      [7:0]          tr_channel_o,
    output logic      [31:0]         tr_src_o,
    output logic      [31:0]         tr_dst_o,
    output logic      [15:0]         tr_array_byte_count_o,
    output logic      [15:0]         tr_frame_array_count_o,
    output logic      [31:0]         tr_options_o,
    output logic                     irq_o
);

    localparam int CH_W  = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam int SET_W = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
    localparam int MA_W  = SET_W + 3;
    localparam int MEM_N = NUM_SETS * 8;
    localparam logic [`ADDR_W-1:0] MEM_WORDS = `ADDR_W'(MEM_N);

    // ****************
    // Elaboration checks
    // ****************
    // Channel n owns set n, flags fit one word, memory sits below bit 11.
    if (NUM_CH < 1 || NUM_CH > 32 || (1 << CH_W) != NUM_CH || NUM_SETS < NUM_CH
        || NUM_SETS > 256 || (1 << SET_W) != NUM_SETS)
    begin : g_bad_params
        $error("Unsupported channel or parameter set count.");
    end

    // ****************
    // State
    // ****************
    logic [31:0]       mem_q [MEM_N];
    logic [31:0]       set_q [8];
    logic [31:0]       set_d [8];
    eng_state_t        state_q, state_d;
    logic [CH_W-1:0]   ch_q, ch_d;
    logic [2:0]        word_q, word_d;
    logic              copy_q, copy_d;
    logic              nul_q, nul_d;
    logic [SET_W-1:0]  lidx_q, lidx_d;
    logic [NUM_CH-1:0] evt_q, evt_d;
    logic [NUM_CH-1:0] sec_q, sec_d;
    logic [NUM_CH-1:0] miss_q, miss_d;
    logic [NUM_CH-1:0] pend_q, pend_d;
    logic [NUM_CH-1:0] mask_q, mask_d;
    logic [NUM_CH-1:0] chain_q, chain_d;
    logic [NUM_CH-1:0] qevt_q, qevt_d;
    logic [NUM_CH-1:0] qmap_q, qmap_d;
    logic [31:0]       rdata_d;
    logic              tr_valid_d;
    logic [31:0]       tr_src_d, tr_dst_d, tr_opt_d;
    logic [15:0]       tr_array_byte_count_d, tr_frame_array_count_d;
    logic              mem_we;
    logic [MA_W-1:0]   mem_waddr;
    logic [31:0]       mem_wdata;

    // ****************
    // Register port decode
    // ****************
    logic ctrl_sel;
    logic mem_sel;
    assign ctrl_sel = addr_i[`CTRL_SEL_BIT];
    assign mem_sel  = !ctrl_sel && (addr_i < MEM_WORDS);

    always_comb
    begin
        rdata_d = '0;
        if (rd_i && ctrl_sel)
        begin
            case (addr_i[3:0])
                `R_EVENT:       rdata_d = 32'(evt_q);
                `R_SECONDARY:   rdata_d = 32'(sec_q);
                `R_MISSED:      rdata_d = 32'(miss_q);
                `R_PENDING:     rdata_d = 32'(pend_q);
                `R_IRQ_MASK:    rdata_d = 32'(mask_q);
                `R_CHAINED:     rdata_d = 32'(chain_q);
                `R_QUICK_EVENT: rdata_d = 32'(qevt_q);
                `R_QUICK_MAP:   rdata_d = 32'(qmap_q);
                `R_ENGINE:      rdata_d = {22'h0, 8'(ch_q), state_q};
                default:        rdata_d = '0;
            endcase
        end
        else if (rd_i && mem_sel)
        begin
            rdata_d = mem_q[addr_i[MA_W-1:0]];
        end
    end

    // ****************
    // Engine and flags
    // ****************
    always_comb
    begin
        logic [15:0]       array_byte_count, frame_array_count, block_frame_count, link;
        logic [31:0]       options_word;
        logic              zero_any, zero_all, exhaust, found;
        logic [CH_W-1:0]   pick, tcc;
        logic [NUM_CH-1:0] ready, wclr;
        array_byte_count     = set_q[`W_CNT_AB][15:0];
        frame_array_count     = set_q[`W_CNT_AB][31:16];
        block_frame_count     = set_q[`W_CNT_C][15:0];
        link     = set_q[`W_LINK][15:0];
        options_word      = set_q[`W_OPT];
        tcc      = options_word[`OPT_TCC_LSB +: CH_W];
        zero_all = (array_byte_count == 16'h0) && (frame_array_count == 16'h0) && (block_frame_count == 16'h0);
        zero_any = (array_byte_count == 16'h0) || (frame_array_count == 16'h0) || (block_frame_count == 16'h0);
        exhaust  = 1'b0;
        found    = 1'b0;
        pick     = '0;
        wclr     = wdata_i[NUM_CH-1:0];
        ready    = evt_q & ~sec_q;
        state_d  = state_q;
        ch_d     = ch_q;
        word_d   = word_q;
        set_d    = set_q;
        copy_d   = copy_q;
        nul_d    = nul_q;
        lidx_d   = lidx_q;
        evt_d    = evt_q;
        sec_d    = sec_q;
        miss_d   = miss_q;
        pend_d   = pend_q;
        mask_d   = mask_q;
        chain_d  = chain_q;
        qevt_d   = qevt_q;
        qmap_d   = qmap_q;
        tr_valid_d = 1'b0;
        tr_src_d   = tr_src_o;
        tr_dst_d   = tr_dst_o;
        tr_opt_d   = tr_options_o;
        tr_array_byte_count_d  = tr_array_byte_count_o;
        tr_frame_array_count_d  = tr_frame_array_count_o;
        mem_we     = 1'b0;
        mem_waddr  = addr_i[MA_W-1:0];
        mem_wdata  = wdata_i;

        // Software clears come first so that hardware sets below win.
        if (wr_i && ctrl_sel)
        begin
            case (addr_i[3:0])
                `R_EVENT:       evt_d   = evt_q | (wclr & ~sec_q);
                `R_SECONDARY:   sec_d   = sec_q & ~wclr; // R11
                `R_MISSED:      miss_d  = miss_q & ~wclr;
                `R_IRQ_MASK:    mask_d  = wclr;
                `R_CHAINED:     chain_d = chain_q & ~wclr;
                `R_QUICK_EVENT: qevt_d  = qevt_q & ~wclr;
                `R_QUICK_MAP:   qmap_d  = wclr;
                default:        ;
            endcase
        end
        if (rd_i && ctrl_sel && addr_i[3:0] == `R_PENDING)
        begin
            pend_d = '0;
        end
        evt_d = evt_d | (event_i & ~sec_q); // R11

        case (state_q)
            ST_IDLE:
            begin
                for (int i = NUM_CH - 1; i >= 0; i--)
                begin
                    if (ready[i])
                    begin
                        found = 1'b1;
                        pick  = CH_W'(i);
                    end
                end
                if (found)
                begin
                    ch_d        = pick;
                    evt_d[pick] = 1'b0;
                    sec_d[pick] = 1'b1;
                    word_d      = '0;
                    state_d     = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                set_d[word_q] = mem_q[{SET_W'(ch_q), word_q}];
                word_d        = word_q + 3'h1;
                if (word_q == `W_LAST)
                begin
                    state_d = ST_EVAL;
                end
            end
            ST_EVAL:
            begin
                // R17
                if (zero_any)
                begin
                    if (zero_all)
                    begin
                        miss_d[ch_q] = 1'b1; // R10
                    end
                    else
                    begin
                        sec_d[ch_q] = 1'b0; // R12
                    end
                    if (options_word[`OPT_INT_EN])
                    begin
                        pend_d[tcc] = 1'b1; // R14
                    end
                    if (options_word[`OPT_CHAIN_EN])
                    begin
                        chain_d[tcc] = 1'b1; // R14
                    end
                    exhaust = 1'b1; // R13
                end
                else
                begin
                    tr_valid_d  = 1'b1;
                    tr_src_d    = set_q[`W_SRC];
                    tr_dst_d    = set_q[`W_DST];
                    tr_opt_d    = options_word;
                    tr_array_byte_count_d   = array_byte_count;
                    tr_frame_array_count_d   = options_word[`OPT_SYNC_AB] ? frame_array_count : 16'h1;
                    sec_d[ch_q] = 1'b0;
                    if (!options_word[`OPT_SYNC_AB] && frame_array_count > 16'h1)
                    begin
                        set_d[`W_SRC] = set_q[`W_SRC]
                            + {{16{set_q[`W_ARRAY_IDX][15]}}, set_q[`W_ARRAY_IDX][15:0]}; // R01 R18
                        set_d[`W_DST] = set_q[`W_DST]
                            + {{16{set_q[`W_ARRAY_IDX][31]}}, set_q[`W_ARRAY_IDX][31:16]}; // R02
                        set_d[`W_CNT_AB][31:16] = frame_array_count - 16'h1;
                    end
                    else if (block_frame_count > 16'h1)
                    begin
                        set_d[`W_SRC] = set_q[`W_SRC]
                            + {{16{set_q[`W_FRAME_IDX][15]}}, set_q[`W_FRAME_IDX][15:0]}; // R03 R18
                        set_d[`W_DST] = set_q[`W_DST]
                            + {{16{set_q[`W_FRAME_IDX][31]}}, set_q[`W_FRAME_IDX][31:16]}; // R04
                        set_d[`W_CNT_C][15:0] = block_frame_count - 16'h1;
                        if (!options_word[`OPT_SYNC_AB])
                        begin
                            set_d[`W_CNT_AB][31:16] = set_q[`W_LINK][31:16];
                        end
                    end
                    else
                    begin
                        exhaust = 1'b1; // R05
                    end
                end
                word_d = '0;
                copy_d = exhaust && (link != `LINK_NULL);
                nul_d  = exhaust && (link == `LINK_NULL);
                // Pointers beyond implemented memory wrap onto it.
                lidx_d = SET_W'((link & `LINK_KEEP_MASK) >> `LINK_SET_LSB); // R07
                state_d = options_word[`OPT_STATIC] ? ST_IDLE : ST_STORE; // R16
            end
            ST_STORE:
            begin
                // Software writes here are dropped; the bus never stalls.
                mem_we    = 1'b1;
                mem_waddr = {SET_W'(ch_q), word_q};
                if (copy_q)
                begin
                    mem_wdata = mem_q[{lidx_q, word_q}]; // R05 R15
                end
                else if (nul_q)
                begin
                    mem_wdata = (word_q == `W_LINK) ? `NULL_LINK_WORD : `WORD_RST; // R09
                end
                else
                begin
                    mem_wdata = set_q[word_q];
                end
                word_d = word_q + 3'h1;
                if (word_q == `W_LAST)
                begin
                    state_d = ST_IDLE;
                    if ((copy_q || nul_q) && qmap_q[ch_q])
                    begin
                        qevt_d[ch_q] = 1'b1; // R13
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase

        if (!mem_we && wr_i && mem_sel)
        begin
            mem_we = 1'b1;
        end
    end

    // ****************
    // Registers
    // ****************
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < MEM_N; i++)
            begin
                mem_q[i] <= `WORD_RST;
            end
        end
        else if (mem_we)
        begin
            mem_q[mem_waddr] <= mem_wdata;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= ST_IDLE;
            ch_q    <= '0;
            word_q  <= '0;
            copy_q  <= 1'b0;
            nul_q   <= 1'b0;
            lidx_q  <= '0;
            for (int i = 0; i < 8; i++)
            begin
                set_q[i] <= `WORD_RST;
            end
            evt_q   <= '0;
            sec_q   <= '0;
            miss_q  <= '0;
            pend_q  <= '0;
            mask_q  <= NUM_CH'(`FLAGS_RST);
            chain_q <= '0;
            qevt_q  <= '0;
            qmap_q  <= NUM_CH'(`FLAGS_RST);
            rdata_o <= '0;
            tr_valid_o             <= 1'b0;
            tr_channel_o           <= '0;
            tr_src_o               <= '0;
            tr_dst_o               <= '0;
            tr_options_o           <= '0;
            tr_array_byte_count_o  <= '0;
            tr_frame_array_count_o <= '0;
        end
        else
        begin
            state_q <= state_d;
            ch_q    <= ch_d;
            word_q  <= word_d;
            copy_q  <= copy_d;
            nul_q   <= nul_d;
            lidx_q  <= lidx_d;
            set_q   <= set_d;
            evt_q   <= evt_d;
            sec_q   <= sec_d;
            miss_q  <= miss_d;
            pend_q  <= pend_d;
            mask_q  <= mask_d;
            chain_q <= chain_d;
            qevt_q  <= qevt_d;
            qmap_q  <= qmap_d;
            rdata_o <= rdata_d;
            tr_valid_o             <= tr_valid_d;
            tr_channel_o           <= 8'(ch_q);
            tr_src_o               <= tr_src_d;
            tr_dst_o               <= tr_dst_d;
            tr_options_o           <= tr_opt_d;
            tr_array_byte_count_o  <= tr_array_byte_count_d;
            tr_frame_array_count_o <= tr_frame_array_count_d;
        end
    end

    // Level interrupt while any unmasked pending-interrupt flag stands.
    assign irq_o = |(pend_q & mask_q);

endmodule

// >>> dma_link_defs.svh
// Constants of the parameter-set update engine.
// Assumes inclusion by bare name.
`ifndef DMA_LINK_DEFS_SVH
`define DMA_LINK_DEFS_SVH

// ****************
// Set word slots
// ****************
`define W_OPT          3'h0
`define W_SRC          3'h1
`define W_CNT_AB       3'h2
`define W_DST          3'h3
`define W_ARRAY_IDX    3'h4
`define W_LINK         3'h5
`define W_FRAME_IDX    3'h6
`define W_CNT_C        3'h7
`define W_LAST         3'h7

// ****************
// Options word fields
// ****************
`define OPT_STATIC     3
`define OPT_SYNC_AB    2
`define OPT_TCC_LSB    12
`define OPT_INT_EN     20
`define OPT_CHAIN_EN   22

// ****************
// Reload pointer values
// ****************
`define LINK_NULL      16'hffff
`define LINK_KEEP_MASK 16'h3fff
`define LINK_SET_LSB   5
`define NULL_LINK_WORD 32'h0000ffff

// ****************
// Register port
// ****************
`define ADDR_W         12
`define CTRL_SEL_BIT   11
`define R_EVENT        4'h0
`define R_SECONDARY    4'h1
`define R_MISSED       4'h2
`define R_PENDING      4'h3
`define R_IRQ_MASK     4'h4
`define R_CHAINED      4'h5
`define R_QUICK_EVENT  4'h6
`define R_QUICK_MAP    4'h7
`define R_ENGINE       4'h8
`define FLAGS_RST      32'h00000000
`define WORD_RST       32'h00000000

`endif

// >>> dma_link_pkg.sv
// Types shared by the parameter-set update and link engine.
// Assumes nothing of its surroundings.
package dma_link_pkg;

    // Gray sequence along idle, load, evaluate, store.
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_LOAD  = 2'b01,
        ST_EVAL  = 2'b11,
        ST_STORE = 2'b10
    } eng_state_t;

endpackage

// >>> dma_link_update_chk.sv
// Checker bound to the parameter-set update engine.
// Assumes it sees only the engine's ports.
`timescale 1ns/1ps
`include "dma_link_defs.svh"

module dma_link_update_chk #(
    parameter int NUM_CH   = 8,
    parameter int NUM_SETS = 16
)
(
    input wire logic               ref_clk_i,
    input wire logic               arst_n_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic               rd_i,
    input wire logic [31:0]        rdata_o,
    input wire logic               tr_valid_o,
    input wire logic [7:0]         tr_channel_o,
    input wire logic [31:0]        tr_src_o,
    input wire logic [31:0]        tr_dst_o,
    input wire logic [15:0]        tr_array_byte_count_o,
    input wire logic [15:0]        tr_frame_array_count_o,
    input wire logic [31:0]        tr_options_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    // ********************
    // Request spacing
    // ********************
    // Eight quiet cycles: load of the next set always takes that long.
    sequence s_quiet8;
        !tr_valid_o [*8];
    endsequence

    a_tr_spacing: assert property (tr_valid_o |=> s_quiet8 ##1 !tr_valid_o)
        else $error("Requests closer than one load phase");
    a_store_gap: assert property (tr_valid_o && !tr_options_o[`OPT_STATIC]
        |=> s_quiet8 ##1 s_quiet8 ##1 !tr_valid_o)
        else $error("Request during the eight word store phase");
    a_counts_nonzero: assert property (tr_valid_o |->
        tr_array_byte_count_o != 16'h0000 && tr_frame_array_count_o != 16'h0000)
        else $error("Request submitted with a zero count");
    a_array_sync_one: assert property (tr_valid_o && !tr_options_o[`OPT_SYNC_AB]
        |-> tr_frame_array_count_o == 16'h0001)
        else $error("Array synchronized request not one array long");
    a_addr_hold: assert property (!tr_valid_o |-> $stable(tr_src_o)
        && $stable(tr_dst_o) && $stable(tr_options_o))
        else $error("Request fields moved without a request");
    a_channel_range: assert property (tr_valid_o |-> tr_channel_o < 8'(NUM_CH))
        else $error("Request for a channel that does not exist");

    // ********************
    // Register reads
    // ********************
    a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h00000000)
        else $error("Read data outside the read answer cycle");
    a_unmapped_zero: assert property (rd_i && addr_i[`CTRL_SEL_BIT]
        && addr_i[3:0] > `R_ENGINE |=> rdata_o == 32'h00000000)
        else $error("Unmapped control read not zero");
    a_flag_upper_zero: assert property (rd_i && addr_i[`CTRL_SEL_BIT]
        && addr_i[3:0] < `R_ENGINE |=> rdata_o[31:NUM_CH] == '0)
        else $error("Flag register upper bits not zero");
endmodule

bind dma_parameter_memory_index_link_update dma_link_update_chk #(
    .NUM_CH(NUM_CH), .NUM_SETS(NUM_SETS)) i_dma_link_update_chk (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .tr_valid_o(tr_valid_o), .tr_channel_o(tr_channel_o),
    .tr_src_o(tr_src_o), .tr_dst_o(tr_dst_o), .tr_options_o(tr_options_o),
    .tr_array_byte_count_o(tr_array_byte_count_o),
    .tr_frame_array_count_o(tr_frame_array_count_o));

// >>> tr_sink_model.sv
// Transfer controller stand-in: accepts every submitted request at once.
// Assumes requests come as one-cycle valid pulses on the controller clock.
`timescale 1ns/1ps

module tr_sink_model (
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        tr_valid_i,
    output logic      [15:0] req_cnt_o
);
    logic [15:0] req_cnt_q;
    logic [15:0] req_cnt_d;

    always_comb
    begin
        req_cnt_d = req_cnt_q + {15'h0000, tr_valid_i};
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            req_cnt_q <= 16'h0000;
        else
            req_cnt_q <= req_cnt_d;
    end

    assign req_cnt_o = req_cnt_q;
endmodule

// >>> tb.sv
// Bench: an integer model of the parameter sets checks every request and read.
// Assumes the checker and the sink model are compiled alongside.
`timescale 1ns/1ps

module tb;
    logic        ref_clk_i = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic [11:0] addr_i    = 12'h000;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [7:0]  event_i   = 8'h00;
    logic [31:0] rdata_o, tr_src_o, tr_dst_o, tr_options_o;
    logic [15:0] tr_array_byte_count_o, tr_frame_array_count_o, req_cnt;
    logic [7:0]  tr_channel_o, sec_m, mis_m, pend_m, chn_m, qk_m, qmap_m;
    logic        tr_valid_o, irq_o;
    logic [31:0] mem_m [0:127];
    logic [31:0] s0 [8], s1 [8], s2 [8], s8 [8];
    int          error_cnt, num_checks, trs;

    always #50 ref_clk_i = ~ref_clk_i;

    dma_parameter_memory_index_link_update #(.NUM_CH(8), .NUM_SETS(16)) i_dma_parameter_memory_index_link_update (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i),
        .tr_valid_o(tr_valid_o), .tr_channel_o(tr_channel_o), .tr_src_o(tr_src_o),
        .tr_dst_o(tr_dst_o), .tr_array_byte_count_o(tr_array_byte_count_o),
        .tr_frame_array_count_o(tr_frame_array_count_o), .tr_options_o(tr_options_o),
        .irq_o(irq_o));

    tr_sink_model i_tr_sink_model (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .tr_valid_i(tr_valid_o),
        .req_cnt_o(req_cnt));

    // ********************
    // Checking and bus tasks
    // ********************
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        if (!a[11])
            mem_m[a[6:0]] = v;
    endtask

    // Read data is taken in the single cycle after the read edge.
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(rdata_o, e);
    endtask

    task automatic cmp_set(input int ch);
        for (int i = 0; i < 8; i++)
            rc(12'(ch * 8 + i), mem_m[ch * 8 + i]);
    endtask

    task automatic chk_flags();
        rc(12'h801, {24'h0, sec_m});
        rc(12'h802, {24'h0, mis_m});
        rc(12'h803, {24'h0, pend_m});
        pend_m = 8'h00;
        rc(12'h805, {24'h0, chn_m});
        rc(12'h806, {24'h0, qk_m});
    endtask

    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    // ********************
    // Behavioural model of one service
    // ********************
    task automatic svc(input int ch, output bit t, output logic [31:0] es, ed, eo, ec);
        logic [31:0] w [8];
        int          b, c, p;
        bit          rl;
        t  = 1'b0;
        rl = 1'b0;
        if (sec_m[ch])
            return;
        for (int i = 0; i < 8; i++)
            w[i] = mem_m[ch * 8 + i];
        b = w[2][31:16];
        c = w[7][15:0];
        if (w[2][15:0] == 0 || b == 0 || c == 0)
        begin
            if (w[2][15:0] == 0 && b == 0 && c == 0)
                {mis_m[ch], sec_m[ch]} = 2'b11;
            pend_m[w[0][14:12]] |= w[0][20];
            chn_m[w[0][14:12]]  |= w[0][22];
            rl = !w[0][3];
        end
        else
        begin
            t  = 1'b1;
            es = w[1];
            ed = w[3];
            eo = w[0];
            ec = {w[2][15:0], w[0][2] ? w[2][31:16] : 16'h0001};
            if (w[0][3])
                rl = 1'b0;
            else if (!w[0][2] && b > 1)
            begin
                w[1] += sx(w[4][15:0]);
                w[3] += sx(w[4][31:16]);
                w[2][31:16] -= 16'h0001;
            end
            else if (c > 1)
            begin
                w[1] += sx(w[6][15:0]);
                w[3] += sx(w[6][31:16]);
                w[7][15:0] -= 16'h0001;
                if (!w[0][2])
                    w[2][31:16] = w[5][31:16];
            end
            else
                rl = 1'b1;
        end
        if (rl)
        begin
            p = w[5][15:0];
            for (int i = 0; i < 8; i++)
                w[i] = (p == 'hffff) ? ((i == 5) ? 32'h0000ffff : 32'h0)
                     : mem_m[(((p & 'h3fff) >> 5) % 16) * 8 + i];
            qk_m[ch] |= qmap_m[ch];
        end
        for (int i = 0; i < 8; i++)
            mem_m[ch * 8 + i] = w[i];
    endtask

    task automatic fire(input int ch);
        bit          t, seen;
        logic [31:0] es, ed, eo, ec;
        svc(ch, t, es, ed, eo, ec);
        trs += t;
        seen = 1'b0;
        @(posedge ref_clk_i);
        event_i <= 8'h01 << ch;
        @(posedge ref_clk_i);
        event_i <= 8'h00;
        repeat (26)
        begin
            @(negedge ref_clk_i);
            if (tr_valid_o === 1'b1)
            begin
                seen = 1'b1;
                chk(tr_src_o, es);
                chk(tr_dst_o, ed);
                chk({tr_array_byte_count_o, tr_frame_array_count_o}, ec);
                chk(tr_options_o, eo);
                chk({24'h0, tr_channel_o}, 32'(ch));
            end
        end
        chk({31'h0, seen}, {31'h0, t});
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        wrap_up();
    end

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        void'($urandom(12));
        {sec_m, mis_m, pend_m, chn_m, qk_m, qmap_m} = '0;
        for (int i = 0; i < 128; i++)
            mem_m[i] = 32'h0;
        // Reload pointers other than all-ones are aligned and inside memory; one carries bit 14.
        s0 = '{32'h0, $urandom, 32'h00020004, $urandom, {16'h8000, 16'($urandom)},
               32'h00024100, {16'($urandom), 16'h7fff}, 32'h2};
        s8 = '{32'h4, $urandom, 32'h00030010, $urandom, $urandom, 32'h0000ffff,
               $urandom, 32'h2};
        s1 = '{32'h00501000, $urandom, 32'h00010000, $urandom, $urandom, 32'h00000100,
               $urandom, 32'h1};
        s2 = '{32'hc, $urandom, 32'h00040008, $urandom, $urandom, 32'h0000ffff,
               $urandom, 32'h3};
        repeat (8) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            wr(12'(i), s0[i]);
            wr(12'(8 + i), s1[i]);
            wr(12'(16 + i), s2[i]);
            wr(12'(64 + i), s8[i]);
        end
        wr(12'h807, 32'h2);
        qmap_m = 8'h02;
        repeat (6) fire(0);
        cmp_set(0);
        fire(0);
        fire(0);
        rc(12'h800, 32'h0);
        chk_flags();
        wr(12'h801, 32'h1);
        wr(12'h802, 32'h1);
        {sec_m, mis_m} = '0;
        fire(1);
        chk({31'h0, irq_o}, 32'h0);
        wr(12'h804, 32'h2);
        @(negedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h1);
        chk_flags();
        chk({31'h0, irq_o}, 32'h0);
        cmp_set(1);
        fire(1);
        fire(2);
        fire(2);
        cmp_set(2);
        rc(12'h80f, 32'h0);
        rc(12'h7f0, 32'h0);
        chk({16'h0, req_cnt}, 32'(trs));
        wrap_up();
    end
endmodule
